// file: logic/fsd_top.sv
// sequencer for the store and subtract group of the stack unit
// assumes: opcode bytes, busy and done come from logic on mclk
// Function
// RULE1: dd with 1101 0 n copies the stack top to register n; dd or d9 with reg 010 stores it as 64- or 32-bit real.
// RULE2: store_real and store_real_pop to register or memory finish in 2 clocks.
// RULE3: store_packed_decimal_pop takes 57 to 63 clocks.
// RULE4: store_integer writes 64, 32 or 16 bits, popping forms use reg 011 and pop after the write; the code decodes the 64-bit popping form from df reg 111.
// RULE5: store_control_word_waiting waits for idle and takes 5 clocks, the nowait form 3.
// RULE6: environment store takes 14 to 24 clocks waiting and 12 to 22 without.
// RULE7: status store to memory takes 6 or 4 clocks, to ax 4 or 2, waiting or not.
// RULE8: real_subtract register forms are dc 1110 1 n into register n and d8 1110 0 n into the stack top.
// RULE9: memory real_subtract uses reg 100, dc for 64-bit and d8 for 32-bit, result in the stack top.
// RULE10: real_subtract_pop under de subtracts into register n then pops; real subtracts take 4 to 7 clocks.
// RULE11: real_subtract_reversed swaps operands, using dc 1110 0 n, d8 1110 1 n, reg 101 and de 1110 0 n.
// RULE12: integer_subtract with reg 100 uses da for 32 bits in 14 to 29 clocks and de for 16 bits in 14 to 27.
// RULE13: integer_subtract_reversed with reg 101 computes memory minus stack top into the stack top.
// RULE14: a pop increments the stack-top pointer and discards the value, a push decrements it.
// RULE15: stack-relative references use the layout that exists before the instruction runs.
// RULE16: wait_idle_instruction stalls until the unit is not busy and takes 2 clocks.
// RULE17: the three-bit n field picks one of eight registers counted from the stack top.
`timescale 1ns/1ps
`default_nettype none
`include "fsd_defs.svh"
module fsd_top
	import fsd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       op_valid,
	input  wire logic       op_wait_prefix,
	input  wire logic [7:0] op_b1,
	input  wire logic [7:0] op_b2,
	input  wire logic       fpu_busy,
	input  wire logic       exec_done,
	input  wire logic       push_req,
	output var  logic       op_ready,
	output var  logic       busy,
	output var  logic       done,
	output var  fsd_kind_t  kind,
	output var  fsd_width_t width,
	output var  logic       mem_op,
	output var  logic       reversed,
	output var  logic       pop,
	output var  logic       dst_is_n,
	output var  logic       to_ax,
	output var  logic [2:0] n_phys,
	output var  logic [2:0] stack_top,
	output var  logic [5:0] cycles
);
	fsd_dec_if dif ();
	assign dif.b1 = op_b1;
	assign dif.b2 = op_b2;
	assign dif.pfx = op_wait_prefix;
	fsd_decode u_dec (
		.dp (dif.dec)
	);

	fsd_st_t r;
	fsd_st_t next_r;
	logic    accept;
	logic    fin;

	assign accept = ce & op_valid & r.ready;

	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		fin = 1'b0;
		unique case (r.state)
		S_IDLE: begin
			if (accept) begin
				next_r.d = dif.d;
				// operand index frozen from the pre-execution top [RULE15]
				next_r.n_phys = 3'(r.top + op_b2[2:0]); // [RULE17]
				next_r.cnt = 6'h01;
				next_r.ready = 1'b0;
				next_r.busy = 1'b1;
				next_r.state = dif.d.waits ? S_WAITI : S_EXEC; // [RULE5]
			end else if (push_req) begin
				next_r.top = 3'(r.top - 3'h1); // [RULE14]
			end
		end
		S_WAITI: begin
			// counted time starts once the unit is idle [RULE16]
			if (!fpu_busy)
				next_r.state = S_EXEC;
		end
		S_EXEC: begin
			// ranged forms end early on exec_done, never past the max
			fin = (r.cnt >= r.d.cmin) &&
				(exec_done || r.cnt >= r.d.cmax); // [RULE10] [RULE12]
			if (fin) begin
				next_r.state = S_IDLE;
				next_r.ready = 1'b1;
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				if (r.d.pop)
					next_r.top = 3'(r.top + 3'h1); // [RULE4] [RULE14]
			end else begin
				next_r.cnt = 6'(r.cnt + 6'h01);
			end
		end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.state <= S_IDLE;
			r.ready <= 1'b1;
			r.top <= `FSD_TOP_RST;
		end else if (ce) begin
			r <= next_r;
		end
	end

	assign op_ready = r.ready;
	assign busy = r.busy;
	assign done = r.done;
	assign kind = r.d.kind;
	assign width = r.d.width;
	assign mem_op = r.d.mem;
	assign reversed = r.d.rev;
	assign pop = r.d.pop;
	assign dst_is_n = r.d.dst_n;
	assign to_ax = r.d.to_ax;
	assign n_phys = r.n_phys;
	assign stack_top = r.top;
	assign cycles = r.cnt;

	// checks below watch the latched result and the cycle tally
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		accept;
	endsequence
	sequence s_stall;
		ce && r.state == S_WAITI && fpu_busy;
	endsequence

	property p_copy_decode;
		s_take ##0 (op_b1 == `FSD_OP_DD && op_b2[7:3] == `FSD_R5_ST)
			|=> kind == K_STORE && dst_is_n && !pop && !mem_op;
	endproperty
	a_copy_decode: assert property (p_copy_decode) // [RULE1]
		else $error("register copy misdecoded");

	property p_store_time;
		done && kind == K_STORE |-> cycles == `FSD_CYC_STORE;
	endproperty
	a_store_time: assert property (p_store_time) // [RULE2]
		else $error("real store not 2 clocks");

	property p_bcd_time;
		done && kind == K_STORE_BCD |->
			cycles >= `FSD_CYC_BCD_MIN && cycles <= `FSD_CYC_BCD_MAX;
	endproperty
	a_bcd_time: assert property (p_bcd_time) // [RULE3]
		else $error("packed store out of range");

	property p_cw_time;
		done && kind == K_STORE_CW |->
			cycles == (r.d.waits ? `FSD_CYC_CW_W : `FSD_CYC_CW_N);
	endproperty
	a_cw_time: assert property (p_cw_time) // [RULE5]
		else $error("control word store count wrong");

	property p_env_time;
		done && kind == K_STORE_ENV |-> r.d.waits ?
			(cycles >= `FSD_CYC_ENV_W_MIN && cycles <= `FSD_CYC_ENV_W_MAX) :
			(cycles >= `FSD_CYC_ENV_N_MIN && cycles <= `FSD_CYC_ENV_N_MAX);
	endproperty
	a_env_time: assert property (p_env_time) // [RULE6]
		else $error("environment store count wrong");

	property p_sw_time;
		done && kind == K_STORE_SW && to_ax |->
			cycles == (r.d.waits ? `FSD_CYC_AX_W : `FSD_CYC_AX_N);
	endproperty
	a_sw_time: assert property (p_sw_time) // [RULE7]
		else $error("status to ax count wrong");

	property p_sub_decode;
		s_take ##0 (op_b1 == `FSD_OP_D8 && op_b2[7:3] == `FSD_R5_SUB0)
			|=> kind == K_SUB && !dst_is_n && !reversed;
	endproperty
	a_sub_decode: assert property (p_sub_decode) // [RULE8]
		else $error("d8 register subtract misdecoded");

	property p_sub_time;
		done && kind == K_SUB |->
			cycles >= `FSD_CYC_SUB_MIN && cycles <= `FSD_CYC_SUB_MAX;
	endproperty
	a_sub_time: assert property (p_sub_time) // [RULE10]
		else $error("real subtract out of range");

	property p_isub_time;
		done && kind == K_ISUB |-> cycles >= `FSD_CYC_ISUB_MIN &&
			cycles <= (width == W32 ? `FSD_CYC_ISUB32_MAX
			: `FSD_CYC_ISUB16_MAX);
	endproperty
	a_isub_time: assert property (p_isub_time) // [RULE12]
		else $error("integer subtract out of range");

	property p_pop_top;
		// done holds through ce-low cycles, so only its first cycle counts
		$rose(done) && pop |-> stack_top == 3'($past(stack_top) + 3'h1);
	endproperty
	a_pop_top: assert property (p_pop_top) // [RULE14]
		else $error("pop did not advance top");

	property p_resolve;
		s_take |=> n_phys == 3'($past(stack_top) + $past(op_b2[2:0]));
	endproperty
	a_resolve: assert property (p_resolve) // [RULE15]
		else $error("operand index not from old top");

	property p_wait_hold;
		s_stall |=> r.state == S_WAITI && cycles == 6'h01;
	endproperty
	a_wait_hold: assert property (p_wait_hold) // [RULE16]
		else $error("left wait while unit busy");
endmodule
`default_nettype wire

// file: logic/fsd_defs.svh
// opcode bytes, field codes, reset values and clock counts
// assumes: included by bare name from the package and the modules
`ifndef FSD_DEFS_SVH
`define FSD_DEFS_SVH
`define FSD_OP_D8 8'hd8
`define FSD_OP_D9 8'hd9
`define FSD_OP_DA 8'hda
`define FSD_OP_DB 8'hdb
`define FSD_OP_DC 8'hdc
`define FSD_OP_DD 8'hdd
`define FSD_OP_DE 8'hde
`define FSD_OP_DF 8'hdf
`define FSD_OP_WAIT 8'h9b
`define FSD_B2_SW_AX 8'he0
`define FSD_RF_ST 3'h2
`define FSD_RF_STP 3'h3
`define FSD_RF_SUB 3'h4
`define FSD_RF_SUBR 3'h5
`define FSD_RF_ENV 3'h6
`define FSD_RF_CW 3'h7
`define FSD_RF_BCD 3'h6
`define FSD_RF_LI 3'h7
`define FSD_RF_ST80 3'h7
`define FSD_R5_ST 5'h1a
`define FSD_R5_STP 5'h1b
`define FSD_R5_SUB0 5'h1c
`define FSD_R5_SUB1 5'h1d
`define FSD_TOP_RST 3'h0
`define FSD_CYC_NONE 6'h01
`define FSD_CYC_STORE 6'h02
`define FSD_CYC_BCD_MIN 6'h39
`define FSD_CYC_BCD_MAX 6'h3f
`define FSD_CYC_I64_MIN 6'h0a
`define FSD_CYC_I64_MAX 6'h0d
`define FSD_CYC_I32_MIN 6'h08
`define FSD_CYC_I32_MAX 6'h0d
`define FSD_CYC_I16_MIN 6'h07
`define FSD_CYC_I16_MAX 6'h0a
`define FSD_CYC_CW_W 6'h05
`define FSD_CYC_CW_N 6'h03
`define FSD_CYC_ENV_W_MIN 6'h0e
`define FSD_CYC_ENV_W_MAX 6'h18
`define FSD_CYC_ENV_N_MIN 6'h0c
`define FSD_CYC_ENV_N_MAX 6'h16
`define FSD_CYC_SW_W 6'h06
`define FSD_CYC_SW_N 6'h04
`define FSD_CYC_AX_W 6'h04
`define FSD_CYC_AX_N 6'h02
`define FSD_CYC_SUB_MIN 6'h04
`define FSD_CYC_SUB_MAX 6'h07
`define FSD_CYC_ISUB_MIN 6'h0e
`define FSD_CYC_ISUB32_MAX 6'h1d
`define FSD_CYC_ISUB16_MAX 6'h1b
`define FSD_CYC_WAIT 6'h02
`endif

// file: logic/fsd_pkg.sv
// types shared by the decoder, its carrier and the sequencer
// assumes: fsd_defs.svh on the include path
`include "fsd_defs.svh"
package fsd_pkg;
	typedef enum logic [3:0] {
		K_NONE, K_STORE, K_STORE_BCD, K_STORE_INT, K_STORE_CW,
		K_STORE_ENV, K_STORE_SW, K_SUB, K_ISUB, K_WAIT
	} fsd_kind_t;
	typedef enum logic [2:0] {W16, W32, W64, W80, WBCD} fsd_width_t;
	typedef enum logic [2:0] {
		S_IDLE  = 3'h1,
		S_WAITI = 3'h2,
		S_EXEC  = 3'h4
	} fsd_state_t;
	typedef struct packed {
		fsd_kind_t  kind;
		fsd_width_t width;
		logic       mem;
		logic       rev;
		logic       pop;
		logic       dst_n;
		logic       to_ax;
		logic       waits;
		logic [5:0] cmin;
		logic [5:0] cmax;
	} fsd_dec_t;
	typedef struct packed {
		fsd_state_t state;
		logic       ready;
		logic       busy;
		logic       done;
		fsd_dec_t   d;
		logic [2:0] n_phys;
		logic [2:0] top;
		logic [5:0] cnt;
	} fsd_st_t;
endpackage

// file: logic/fsd_dec_if.sv
// carrier between the sequencer and the opcode decoder
// assumes: same clock domain, purely combinational path
`timescale 1ns/1ps
`default_nettype none
interface fsd_dec_if;
	import fsd_pkg::*;
	logic [7:0] b1;
	logic [7:0] b2;
	logic       pfx;
	fsd_dec_t   d;
	modport dec (input b1, input b2, input pfx, output d);
	modport use_side (output b1, output b2, output pfx, input d);
endinterface
`default_nettype wire

// file: logic/fsd_decode.sv
// opcode decoder for the store and subtract group
// assumes: bytes are stable while the sequencer samples the result
`timescale 1ns/1ps
`default_nettype none
`include "fsd_defs.svh"
module fsd_decode
	import fsd_pkg::*;
(
	fsd_dec_if.dec dp
);
	logic       regf;
	logic [2:0] rf;
	logic [4:0] r5;
	always_comb begin
		regf = (dp.b2[7:6] == 2'b11);
		rf = dp.b2[5:3];
		r5 = dp.b2[7:3];
		dp.d = '0;
		dp.d.kind = K_NONE;
		dp.d.cmin = `FSD_CYC_NONE;
		dp.d.cmax = `FSD_CYC_NONE;
		if (dp.b1 == `FSD_OP_WAIT) begin
			dp.d.kind = K_WAIT; // [RULE16]
			dp.d.waits = 1'b1;
			dp.d.cmin = `FSD_CYC_WAIT;
			dp.d.cmax = `FSD_CYC_WAIT;
		end else if (regf) begin
			// n field counts from the stack top [RULE17]
			if (dp.b1 == `FSD_OP_DD &&
					(r5 == `FSD_R5_ST || r5 == `FSD_R5_STP)) begin
				dp.d.kind = K_STORE; // [RULE1]
				dp.d.width = W80;
				dp.d.dst_n = 1'b1;
				dp.d.pop = (r5 == `FSD_R5_STP);
			end else if ((dp.b1 == `FSD_OP_DC || dp.b1 == `FSD_OP_D8 ||
					dp.b1 == `FSD_OP_DE) &&
					(r5 == `FSD_R5_SUB0 || r5 == `FSD_R5_SUB1)) begin
				dp.d.kind = K_SUB; // [RULE8] [RULE11]
				dp.d.width = W80;
				dp.d.dst_n = (dp.b1 != `FSD_OP_D8);
				dp.d.pop = (dp.b1 == `FSD_OP_DE); // [RULE10]
				dp.d.rev = (dp.b1 == `FSD_OP_D8) ? (r5 == `FSD_R5_SUB1)
					: (r5 == `FSD_R5_SUB0);
			end else if (dp.b1 == `FSD_OP_DF && dp.b2 == `FSD_B2_SW_AX) begin
				dp.d.kind = K_STORE_SW;
				dp.d.to_ax = 1'b1;
			end
		end else begin
			dp.d.mem = 1'b1;
			unique case (dp.b1)
			`FSD_OP_D9, `FSD_OP_DD: begin
				if (rf == `FSD_RF_ST || rf == `FSD_RF_STP) begin
					dp.d.kind = K_STORE; // [RULE1]
					dp.d.width = (dp.b1 == `FSD_OP_DD) ? W64 : W32;
					dp.d.pop = (rf == `FSD_RF_STP);
				end else if (dp.b1 == `FSD_OP_D9 && rf == `FSD_RF_CW)
					dp.d.kind = K_STORE_CW;
				else if (dp.b1 == `FSD_OP_D9 && rf == `FSD_RF_ENV)
					dp.d.kind = K_STORE_ENV;
				else if (dp.b1 == `FSD_OP_DD && rf == `FSD_RF_CW)
					dp.d.kind = K_STORE_SW;
			end
			`FSD_OP_DB, `FSD_OP_DF: begin
				if (rf == `FSD_RF_ST || rf == `FSD_RF_STP) begin
					dp.d.kind = K_STORE_INT; // [RULE4]
					dp.d.width = (dp.b1 == `FSD_OP_DB) ? W32 : W16;
					dp.d.pop = (rf == `FSD_RF_STP);
				end else if (dp.b1 == `FSD_OP_DF && rf == `FSD_RF_LI) begin
					dp.d.kind = K_STORE_INT;
					dp.d.width = W64;
					dp.d.pop = 1'b1;
				end else if (dp.b1 == `FSD_OP_DF && rf == `FSD_RF_BCD) begin
					dp.d.kind = K_STORE_BCD; // [RULE3]
					dp.d.width = WBCD;
					dp.d.pop = 1'b1;
				end else if (dp.b1 == `FSD_OP_DB && rf == `FSD_RF_ST80) begin
					dp.d.kind = K_STORE;
					dp.d.width = W80;
					dp.d.pop = 1'b1;
				end
			end
			`FSD_OP_D8, `FSD_OP_DC, `FSD_OP_DA, `FSD_OP_DE: begin
				if (rf == `FSD_RF_SUB || rf == `FSD_RF_SUBR) begin
					dp.d.rev = (rf == `FSD_RF_SUBR); // [RULE9] [RULE13]
					if (dp.b1 == `FSD_OP_D8 || dp.b1 == `FSD_OP_DC) begin
						dp.d.kind = K_SUB;
						dp.d.width = (dp.b1 == `FSD_OP_DC) ? W64 : W32;
					end else begin
						dp.d.kind = K_ISUB; // [RULE12]
						dp.d.width = (dp.b1 == `FSD_OP_DA) ? W32 : W16;
					end
				end
			end
			default: dp.d.kind = K_NONE;
			endcase
		end
		// clock counts; waiting forms carry the 9b prefix [RULE5]
		if (dp.d.kind inside {K_STORE_CW, K_STORE_ENV, K_STORE_SW})
			dp.d.waits = dp.pfx;
		unique case (dp.d.kind)
		K_STORE: begin
			dp.d.cmin = `FSD_CYC_STORE; // [RULE2]
			dp.d.cmax = `FSD_CYC_STORE;
		end
		K_STORE_BCD: begin
			dp.d.cmin = `FSD_CYC_BCD_MIN;
			dp.d.cmax = `FSD_CYC_BCD_MAX;
		end
		K_STORE_INT: begin
			dp.d.cmin = (dp.d.width == W64) ? `FSD_CYC_I64_MIN
				: (dp.d.width == W32) ? `FSD_CYC_I32_MIN : `FSD_CYC_I16_MIN;
			dp.d.cmax = (dp.d.width == W64) ? `FSD_CYC_I64_MAX
				: (dp.d.width == W32) ? `FSD_CYC_I32_MAX : `FSD_CYC_I16_MAX;
		end
		K_STORE_CW: begin
			dp.d.cmin = dp.pfx ? `FSD_CYC_CW_W : `FSD_CYC_CW_N;
			dp.d.cmax = dp.d.cmin;
		end
		K_STORE_ENV: begin // [RULE6]
			dp.d.cmin = dp.pfx ? `FSD_CYC_ENV_W_MIN : `FSD_CYC_ENV_N_MIN;
			dp.d.cmax = dp.pfx ? `FSD_CYC_ENV_W_MAX : `FSD_CYC_ENV_N_MAX;
		end
		K_STORE_SW: begin // [RULE7]
			if (dp.d.to_ax)
				dp.d.cmin = dp.pfx ? `FSD_CYC_AX_W : `FSD_CYC_AX_N;
			else
				dp.d.cmin = dp.pfx ? `FSD_CYC_SW_W : `FSD_CYC_SW_N;
			dp.d.cmax = dp.d.cmin;
		end
		K_SUB: begin
			dp.d.cmin = `FSD_CYC_SUB_MIN;
			dp.d.cmax = `FSD_CYC_SUB_MAX;
		end
		K_ISUB: begin
			dp.d.cmin = `FSD_CYC_ISUB_MIN;
			dp.d.cmax = (dp.d.width == W32) ? `FSD_CYC_ISUB32_MAX
				: `FSD_CYC_ISUB16_MAX;
		end
		K_WAIT, K_NONE: ;
		endcase
	end
endmodule
`default_nettype wire

// file: sim/fsd_far_unit.sv
// far-side model: unit-busy and early-finish signals seen by the sequencer
// assumes: mclk domain; stall length and finish point are set by the bench
`timescale 1ns/1ps
`default_nettype none
module fsd_far_unit (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       busy,
	input  wire logic [5:0] cycles,
	input  wire logic [2:0] stall,
	input  wire logic [5:0] done_at,
	output logic            fpu_busy,
	output logic            exec_done
);
	logic [3:0] cnt;
	// saturating, so a long store never brings the busy flag back mid-run
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			cnt <= 4'h0;
		else if (!busy)
			cnt <= 4'h0;
		else if (ce && cnt != 4'hf)
			cnt <= cnt + 4'h1;
	end
	// busy for the first stall cycles of every instruction, idle otherwise
	assign fpu_busy = busy && (cnt < {1'b0, stall});
	// early finish once the tally reaches the chosen point
	assign exec_done = busy && (cycles >= done_at);
endmodule
`default_nettype wire

// file: sim/test_fpu_store_subtract_decode.sv
// bench for the store and subtract sequencer with its far-side model
// assumes: fsd_pkg, fsd_top and fsd_far_unit are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module test_fpu_store_subtract_decode;
	import fsd_pkg::*;
	// fl holds prefix, pop, memory, reversed, result-to-n, to-ax
	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		fsd_kind_t  kind;
		fsd_width_t width;
		logic [5:0] fl;
		logic [5:0] cmin;
		logic [5:0] cmax;
	} fsd_ent_t;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        ce = 1'b1;
	logic        op_valid = 1'b0;
	logic        op_wait_prefix = 1'b0;
	logic [7:0]  op_b1 = 8'h00;
	logic [7:0]  op_b2 = 8'h00;
	logic        push_req = 1'b0;
	logic [2:0]  stall = 3'h0;
	logic [5:0]  done_at = 6'h00;
	logic        fpu_busy, exec_done, op_ready, busy, done, mem_op;
	logic        reversed, pop, dst_is_n, to_ax;
	fsd_kind_t   kind;
	fsd_width_t  width;
	logic [2:0]  n_phys, stack_top;
	logic [2:0]  exp_top = 3'h0;
	logic [5:0]  cycles;
	logic [31:0] seed = 32'hdea6bcdf;
	logic [31:0] cseed = 32'hdea6bcdf;
	logic        ce_rand = 1'b0;
	int          miscompares = 0;
	int          num_checks = 0;
	int          ticks = 0;

	always #25 mclk = ~mclk;

	fsd_top uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .op_valid(op_valid),
		.op_wait_prefix(op_wait_prefix), .op_b1(op_b1), .op_b2(op_b2),
		.fpu_busy(fpu_busy), .exec_done(exec_done), .push_req(push_req),
		.op_ready(op_ready), .busy(busy), .done(done), .kind(kind),
		.width(width), .mem_op(mem_op), .reversed(reversed), .pop(pop),
		.dst_is_n(dst_is_n), .to_ax(to_ax), .n_phys(n_phys),
		.stack_top(stack_top), .cycles(cycles));
	fsd_far_unit far_unit (.mclk(mclk), .rst_n(rst_n), .ce(ce), .busy(busy),
		.cycles(cycles), .stall(stall), .done_at(done_at),
		.fpu_busy(fpu_busy), .exec_done(exec_done));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic fsd_ent_t ent(input int i);
		case (i)
			0: return {8'hdd,8'hd0,K_STORE,W80,6'h02,6'h02,6'h02};
			1: return {8'hdd,8'hd8,K_STORE,W80,6'h12,6'h02,6'h02};
			2: return {8'hdd,8'h10,K_STORE,W64,6'h08,6'h02,6'h02};
			3: return {8'hd9,8'h10,K_STORE,W32,6'h08,6'h02,6'h02};
			4: return {8'hdd,8'h18,K_STORE,W64,6'h18,6'h02,6'h02};
			5: return {8'hdf,8'h30,K_STORE_BCD,WBCD,6'h18,6'h39,6'h3f};
			6: return {8'hdb,8'h10,K_STORE_INT,W32,6'h08,6'h08,6'h0d};
			7: return {8'hdf,8'h10,K_STORE_INT,W16,6'h08,6'h07,6'h0a};
			8: return {8'hdb,8'h18,K_STORE_INT,W32,6'h18,6'h08,6'h0d};
			9: return {8'hdf,8'h18,K_STORE_INT,W16,6'h18,6'h07,6'h0a};
			10: return {8'hdf,8'h38,K_STORE_INT,W64,6'h18,6'h0a,6'h0d};
			11: return {8'hd9,8'h38,K_STORE_CW,W16,6'h28,6'h05,6'h05};
			12: return {8'hd9,8'h38,K_STORE_CW,W16,6'h08,6'h03,6'h03};
			13: return {8'hd9,8'h30,K_STORE_ENV,W16,6'h28,6'h0e,6'h18};
			14: return {8'hd9,8'h30,K_STORE_ENV,W16,6'h08,6'h0c,6'h16};
			15: return {8'hdd,8'h38,K_STORE_SW,W16,6'h28,6'h06,6'h06};
			16: return {8'hdd,8'h38,K_STORE_SW,W16,6'h08,6'h04,6'h04};
			17: return {8'hdf,8'he0,K_STORE_SW,W16,6'h21,6'h04,6'h04};
			18: return {8'hdf,8'he0,K_STORE_SW,W16,6'h01,6'h02,6'h02};
			19: return {8'hdc,8'he8,K_SUB,W80,6'h02,6'h04,6'h07};
			20: return {8'hd8,8'he0,K_SUB,W80,6'h00,6'h04,6'h07};
			21: return {8'hdc,8'h20,K_SUB,W64,6'h08,6'h04,6'h07};
			22: return {8'hd8,8'h20,K_SUB,W32,6'h08,6'h04,6'h07};
			23: return {8'hde,8'he8,K_SUB,W80,6'h12,6'h04,6'h07};
			24: return {8'hdc,8'he0,K_SUB,W80,6'h06,6'h04,6'h07};
			25: return {8'hd8,8'he8,K_SUB,W80,6'h04,6'h04,6'h07};
			26: return {8'hdc,8'h28,K_SUB,W64,6'h0c,6'h04,6'h07};
			27: return {8'hd8,8'h28,K_SUB,W32,6'h0c,6'h04,6'h07};
			28: return {8'hde,8'he0,K_SUB,W80,6'h16,6'h04,6'h07};
			29: return {8'hda,8'h20,K_ISUB,W32,6'h08,6'h0e,6'h1d};
			30: return {8'hde,8'h20,K_ISUB,W16,6'h08,6'h0e,6'h1b};
			31: return {8'hda,8'h28,K_ISUB,W32,6'h0c,6'h0e,6'h1d};
			32: return {8'hde,8'h28,K_ISUB,W16,6'h0c,6'h0e,6'h1b};
			33: return {8'h9b,8'hc0,K_WAIT,W16,6'h00,6'h02,6'h02};
			35: return {8'hdb,8'h38,K_STORE,W80,6'h18,6'h02,6'h02};
			default: return {8'hd9,8'he4,K_NONE,W16,6'h00,6'h01,6'h01};
		endcase
	endfunction

	function automatic logic [5:0] exec_n(input fsd_ent_t e);
		return (done_at < e.cmin) ? e.cmin
			: (done_at > e.cmax) ? e.cmax : done_at;
	endfunction

	task automatic chk(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic push_one;
		push_req = 1'b1;
		do @(posedge mclk); while (!ce);
		#2;
		push_req = 1'b0;
		exp_top = exp_top - 3'h1;
		chk("stack top after push", 8'(exp_top), 8'(stack_top));
	endtask

	task automatic run_one(input fsd_ent_t e, input logic [2:0] n,
			input logic [1:0] md, input logic [2:0] rm);
		logic       rf;
		logic [2:0] top0;
		int         lat;
		int         wt;
		rf = !e.fl[3] && (e.kind == K_STORE || e.kind == K_SUB);
		wt = (e.fl[5] || e.kind == K_WAIT) ? 1 + int'(stall) : 0;
		top0 = exp_top;
		op_b1 = e.b1;
		op_b2 = e.fl[3] ? {md, e.b2[5:3], rm} : rf ? (e.b2 | {5'h0, n}) : e.b2;
		op_wait_prefix = e.fl[5];
		op_valid = 1'b1;
		do @(posedge mclk); while (!(ce && op_ready));
		#2;
		chk("busy after accept", 8'h01, 8'(busy));
		chk("ready after accept", 8'h00, 8'(op_ready));
		// offer a second opcode while busy: it has to be ignored
		op_b1 = 8'h9b;
		op_wait_prefix = 1'b0;
		lat = 0;
		do begin
			@(posedge mclk);
			if (ce)
				lat++;
			#2;
			op_valid = 1'b0;
		end while (done !== 1'b1);
		chk("latency", 8'(exec_n(e)) + 8'(wt), 8'(lat));
		chk("cycles", 8'(exec_n(e)), 8'(cycles));
		chk("busy at done", 8'h00, 8'(busy));
		chk("ready at done", 8'h01, 8'(op_ready));
		chk("kind", 8'(e.kind), 8'(kind));
		if (!(e.kind inside {K_STORE_CW, K_STORE_ENV, K_STORE_SW}))
			chk("width", 8'(e.width), 8'(width));
		chk("flags", {3'h0, e.fl[4:0]},
			{3'h0, pop, mem_op, reversed, dst_is_n, to_ax});
		if (rf)
			chk("n_phys", 8'(3'(top0 + n)), 8'(n_phys));
		exp_top = top0 + {2'h0, e.fl[4]};
		chk("stack top", 8'(exp_top), 8'(stack_top));
		do @(posedge mclk); while (!ce);
		#2;
		chk("done pulse", 8'h00, 8'(done));
	endtask

	always @(posedge mclk) begin
		#2;
		cseed = xs(cseed);
		ce = !ce_rand || (cseed[2:0] != 3'h0);
	end

	// a full run needs a few thousand cycles; far beyond that is a hang
	always @(posedge mclk) begin
		ticks++;
		if (ticks == 20000) begin
			miscompares++;
			results;
		end
	end

	initial begin
		repeat (5) @(posedge mclk);
		#2;
		chk("stack top at reset", 8'h00, 8'(stack_top));
		rst_n = 1'b1;
		push_one;
		for (int r = 0; r < 4; r++) begin
			@(posedge mclk);
			ce_rand = (r > 1);
			#2;
			for (int i = 0; i < 37; i++) begin
				seed = xs(seed);
				stall = (r == 0) ? 3'h0 : (r == 1) ? 3'h7 : seed[10:8];
				done_at = (r == 0) ? 6'h00 : (r == 1) ? 6'h3f : seed[16:11];
				run_one(ent(i), (r == 0) ? 3'h7 : seed[2:0],
					seed[4] ? 2'h2 : {1'b0, seed[3]}, seed[7:5]);
			end
			$display("round %0d finished", r);
		end
		push_one;
		results;
	end
endmodule
`default_nettype wire
